/* File: logic/pbc_defines.svh */
// register offsets, field positions and constant values of the bridge function config header
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

`define PBC_OFS_CMD_STAT 12'h104
`define PBC_OFS_CLASS_REV 12'h108
`define PBC_OFS_LAT_HDR 12'h10c
`define PBC_OFS_WIN_BASE 12'h110
`define PBC_OFS_INT_ROUTE 12'h13c

`define PBC_BIT_MEM_EN 1
`define PBC_BIT_PAR_RESP 6
`define PBC_BIT_SERR_EN 8
`define PBC_BIT_FAST_B2B 23
`define PBC_BIT_TGT_ABORT 27
`define PBC_BIT_SERR_SIG 30
`define PBC_BIT_PAR_DET 31

`define PBC_SEL_TIMING 2'h1
`define PBC_BASE_CLASS 8'h06
`define PBC_SUB_CLASS 8'h80
`define PBC_PROG_IF 8'h00
`define PBC_HEADER_TYPE 8'h80
`define PBC_INT_PIN 8'h01
`define PBC_WIN_LSB 20

`endif

/* File: logic/pbc_pkg.sv */
// types shared by the bridge function config header
package pbc_pkg;
  typedef logic [31:0] pbc_word_t;
  typedef logic [11:0] pbc_base_t;
  typedef enum logic [1:0] {PBC_IDLE, PBC_READ_DONE, PBC_WRITE_DONE} pbc_cfg_e;
endpackage

/* File: logic/pbc_config_space.sv */
// configuration header of the bridge function: command, status, class, base and interrupt words
//
// Contract
// RULE1 - all command bits zero: only config accesses; target abort is not gated by the command bits
// RULE2 - status writes clear bits written one
// RULE3 - memory enable gates window accesses, resets zero
// RULE4 - software keeps memory enable off in slave mode
// RULE5 - parity response zero ignores parity errors
// RULE6 - system error enable gates error output
// RULE7 - unimplemented command bits read zero
// RULE8 - status 16-22 zero, bit 23 one
// RULE9 - select timing field reads constant 01
// RULE10 - master status bits always read zero
// RULE11 - target abort sets sticky status bit
// RULE12 - abort only when arbitrating without bus
// RULE13 - asserted system error sets sticky bit; code also sets it with system error enable off
// RULE14 - detected parity error always sets sticky bit
// RULE15 - class code reads bridge 06 80 00
// RULE16 - revision byte sits in bits 0-7
// RULE17 - header type 80h, other bytes zero
// RULE18 - base low flags read memory, 32-bit, non-prefetch
// RULE19 - base bits 4-19 zero, 20-31 writable
// RULE20 - interrupt line byte is plain storage
// RULE21 - interrupt pin reads 01h
// RULE22 - minimum grant and maximum latency read zero
// RULE23 - claim window only on base match and enable
`timescale 1ns/1ps
`include "pbc_defines.svh"

module pbc_config_space
  import pbc_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5a // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  // configuration access port
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [3:0] cfg_be_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // memory cycle address for window decode
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_claim_o,
  // events from the target engine
  input wire logic par_err_i,
  input wire logic abort_req_i,
  input wire logic arb_mode_i,
  input wire logic bus_held_i,
  // error, bus state and interrupt line outputs
  output logic serr_n_o,
  output logic target_abort_o,
  output logic mem_enable_o,
  output logic bus_connected_o,
  output logic [7:0] int_line_o
);

  // ========================================
  // state
  logic mem_en_q, mem_en_d;
  logic par_resp_q, par_resp_d;
  logic serr_en_q, serr_en_d;
  logic tgt_abort_q, tgt_abort_d;
  logic serr_sig_q, serr_sig_d;
  logic par_det_q, par_det_d;
  pbc_base_t base_q, base_d;
  logic [7:0] int_line_q, int_line_d;
  pbc_word_t rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic claim_q, claim_d;
  logic serr_n_q, serr_n_d;
  logic abort_q, abort_d;
  pbc_cfg_e cfg_q, cfg_d;
  logic conn_q, conn_d;

  // byte-lane merge of an incoming write
  function automatic pbc_word_t merge_be(input pbc_word_t old_v, input pbc_word_t new_v, input logic [3:0] be);
    pbc_word_t r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ========================================
  // register read images
  pbc_word_t cmd_stat_w, class_w, lat_w, base_w, intr_w;

  // assemble constant and stored fields
  always_comb begin
    cmd_stat_w = 32'h0; // see RULE7 see RULE10
    cmd_stat_w[`PBC_BIT_MEM_EN] = mem_en_q;
    cmd_stat_w[`PBC_BIT_PAR_RESP] = par_resp_q;
    cmd_stat_w[`PBC_BIT_SERR_EN] = serr_en_q;
    cmd_stat_w[`PBC_BIT_FAST_B2B] = 1'b1; // see RULE8
    cmd_stat_w[26:25] = `PBC_SEL_TIMING; // see RULE9
    cmd_stat_w[`PBC_BIT_TGT_ABORT] = tgt_abort_q;
    cmd_stat_w[`PBC_BIT_SERR_SIG] = serr_sig_q;
    cmd_stat_w[`PBC_BIT_PAR_DET] = par_det_q;
    class_w = {`PBC_BASE_CLASS, `PBC_SUB_CLASS, `PBC_PROG_IF, REVISION_ID}; // see RULE15 see RULE16
    lat_w = {8'h00, `PBC_HEADER_TYPE, 16'h0000}; // see RULE17
    base_w = {base_q, 20'h00000}; // see RULE18 see RULE19
    intr_w = {16'h0000, `PBC_INT_PIN, int_line_q}; // see RULE21 see RULE22
  end

  // ========================================
  // next-state logic
  logic wr_cmd, wr_base, wr_int, serr_fire, abort_ok;
  pbc_word_t mrg;

  always_comb begin
    mem_en_d = mem_en_q;
    par_resp_d = par_resp_q;
    serr_en_d = serr_en_q;
    base_d = base_q;
    int_line_d = int_line_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    cfg_d = PBC_IDLE;
    mrg = 32'h0;
    wr_cmd = cfg_wr_i && (cfg_addr_i == `PBC_OFS_CMD_STAT);
    wr_base = cfg_wr_i && (cfg_addr_i == `PBC_OFS_WIN_BASE);
    wr_int = cfg_wr_i && (cfg_addr_i == `PBC_OFS_INT_ROUTE);
    // abort allowed only when arbitrating and bus not held
    abort_ok = abort_req_i && arb_mode_i && !bus_held_i; // see RULE12
    // system error raised on an acted-upon parity error
    serr_fire = par_err_i && par_resp_q;
    if (wr_cmd) begin
      mrg = merge_be(cmd_stat_w, cfg_wdata_i, cfg_be_i);
      mem_en_d = mrg[`PBC_BIT_MEM_EN]; // see RULE3
      par_resp_d = mrg[`PBC_BIT_PAR_RESP]; // see RULE5
      serr_en_d = mrg[`PBC_BIT_SERR_EN]; // see RULE6
    end
    if (wr_base) begin
      mrg = merge_be(base_w, cfg_wdata_i, cfg_be_i);
      base_d = mrg[31:`PBC_WIN_LSB]; // see RULE19
    end
    if (wr_int && cfg_be_i[0]) begin
      int_line_d = cfg_wdata_i[7:0]; // see RULE20
    end
    // sticky status: set wins over write-one clear
    tgt_abort_d = abort_ok | (tgt_abort_q & ~(wr_cmd & cfg_be_i[3] & cfg_wdata_i[`PBC_BIT_TGT_ABORT])); // see RULE2 see RULE11
    serr_sig_d = serr_fire | (serr_sig_q & ~(wr_cmd & cfg_be_i[3] & cfg_wdata_i[`PBC_BIT_SERR_SIG])); // see RULE13
    par_det_d = par_err_i | (par_det_q & ~(wr_cmd & cfg_be_i[3] & cfg_wdata_i[`PBC_BIT_PAR_DET])); // see RULE14
    if (cfg_rd_i) begin
      ack_d = 1'b1;
      cfg_d = PBC_READ_DONE;
      case (cfg_addr_i)
        `PBC_OFS_CMD_STAT: rdata_d = cmd_stat_w;
        `PBC_OFS_CLASS_REV: rdata_d = class_w;
        `PBC_OFS_LAT_HDR: rdata_d = lat_w;
        `PBC_OFS_WIN_BASE: rdata_d = base_w;
        `PBC_OFS_INT_ROUTE: rdata_d = intr_w;
        default: rdata_d = 32'h0;
      endcase
    end else if (cfg_wr_i) begin
      ack_d = 1'b1;
      cfg_d = PBC_WRITE_DONE;
    end
    // window claim needs enable and base match
    claim_d = mem_req_i && mem_en_q && (mem_addr_i[31:`PBC_WIN_LSB] == base_q); // see RULE1 see RULE3 see RULE23
    serr_n_d = ~(serr_fire && serr_en_q); // see RULE6
    abort_d = abort_ok;
    // connected while any writable command bit is set
    conn_d = mem_en_d | par_resp_d | serr_en_d; // see RULE1
  end

  // registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mem_en_q <= 1'b0;
      par_resp_q <= 1'b0;
      serr_en_q <= 1'b0;
      tgt_abort_q <= 1'b0;
      serr_sig_q <= 1'b0;
      par_det_q <= 1'b0;
      base_q <= 12'h000;
      int_line_q <= 8'h00;
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
      claim_q <= 1'b0;
      serr_n_q <= 1'b1;
      abort_q <= 1'b0;
      cfg_q <= PBC_IDLE;
      conn_q <= 1'b0;
    end else begin
      mem_en_q <= mem_en_d;
      par_resp_q <= par_resp_d;
      serr_en_q <= serr_en_d;
      tgt_abort_q <= tgt_abort_d;
      serr_sig_q <= serr_sig_d;
      par_det_q <= par_det_d;
      base_q <= base_d;
      int_line_q <= int_line_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      claim_q <= claim_d;
      serr_n_q <= serr_n_d;
      abort_q <= abort_d;
      cfg_q <= cfg_d;
      conn_q <= conn_d;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_ack_o = ack_q;
  assign mem_claim_o = claim_q;
  assign serr_n_o = serr_n_q;
  assign target_abort_o = abort_q;
  assign mem_enable_o = mem_en_q;
  // disconnected when the whole command word is zero
  assign bus_connected_o = conn_q; // see RULE1
  assign int_line_o = int_line_q;

  // ========================================
  // assertions
  a_claim_needs_enable: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE23
    mem_claim_o |-> $past(mem_en_q) && ($past(mem_addr_i[31:20]) == $past(base_q)))
    else $error("window claimed without enable or base match");
  a_serr_gated: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE6
    !serr_n_o |-> $past(serr_en_q))
    else $error("system error driven while disabled");
  a_serr_sets_status: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE13
    !serr_n_o |-> serr_sig_q)
    else $error("system error without status bit");
  a_parity_sticky: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE14
    par_err_i |=> par_det_q)
    else $error("parity error not recorded");
  a_abort_sticky: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE11
    target_abort_o |-> tgt_abort_q)
    else $error("target abort not recorded");
  a_abort_cond: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE12
    target_abort_o |-> $past(arb_mode_i) && !$past(bus_held_i))
    else $error("abort outside arbitration mode");
  a_status_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE2
    par_det_q && !par_err_i && !(cfg_wr_i && cfg_addr_i == 12'h104 && cfg_be_i[3] && cfg_wdata_i[31]) |=> par_det_q)
    else $error("status bit lost without clear");
  a_const_status: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE9
    cfg_rd_i && cfg_addr_i == 12'h104 |=> cfg_rdata_o[26:23] == 4'h5 && cfg_rdata_o[29:28] == 2'h0)
    else $error("constant status bits wrong");
  a_class_read: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE15
    cfg_rd_i && cfg_addr_i == 12'h108 |=> cfg_rdata_o[31:8] == 24'h068000)
    else $error("class code wrong");
  a_base_low_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE19
    cfg_rd_i && cfg_addr_i == 12'h110 |=> cfg_rdata_o[19:0] == 20'h0)
    else $error("base low bits not zero");

  // configuration answers and constant fields
  a_ack_follows: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE1
    (cfg_rd_i || cfg_wr_i) |=> cfg_ack_o && cfg_q != PBC_IDLE)
    else $error("configuration access not answered");
  a_cmd_const: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE7
    cfg_rd_i && cfg_addr_i == `PBC_OFS_CMD_STAT |=> cfg_rdata_o[15:9] == 7'h00 && cfg_rdata_o[7] == 1'b0
    && cfg_rdata_o[5:2] == 4'h0 && cfg_rdata_o[0] == 1'b0)
    else $error("read-only command bits not zero");
  a_status_low_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE8
    cfg_rd_i && cfg_addr_i == `PBC_OFS_CMD_STAT |=> cfg_rdata_o[22:16] == 7'h00 && cfg_rdata_o[23] == 1'b1)
    else $error("low status bits wrong");
  a_revision_read: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE16
    cfg_rd_i && cfg_addr_i == `PBC_OFS_CLASS_REV |=> cfg_rdata_o[7:0] == REVISION_ID && cfg_rdata_o[15:8] == 8'h00)
    else $error("revision byte wrong");
  a_header_read: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE17
    cfg_rd_i && cfg_addr_i == `PBC_OFS_LAT_HDR |=> cfg_rdata_o == 32'h0080_0000)
    else $error("header word wrong");
  a_int_const: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE21 see RULE22
    cfg_rd_i && cfg_addr_i == `PBC_OFS_INT_ROUTE |=> cfg_rdata_o[31:8] == 24'h00_0001)
    else $error("interrupt pin or grant bytes wrong");

  // stored fields
  a_base_write: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE19
    cfg_wr_i && cfg_addr_i == `PBC_OFS_WIN_BASE && cfg_be_i == 4'hf |=> base_q == $past(cfg_wdata_i[31:20]))
    else $error("window base not stored");
  a_int_line_store: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE20
    cfg_wr_i && cfg_addr_i == `PBC_OFS_INT_ROUTE && cfg_be_i[0] |=> int_line_o == $past(cfg_wdata_i[7:0]))
    else $error("interrupt line not stored");

  // gating by the command word
  a_claim_off: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE3
    !mem_enable_o |=> !mem_claim_o)
    else $error("window claimed with memory space off");
  a_disconnect_idle: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE1
    !bus_connected_o |=> serr_n_o && !mem_claim_o)
    else $error("bus activity while disconnected");
  a_parity_ignored: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE5
    par_err_i && !par_resp_q |=> serr_n_o)
    else $error("parity error acted on while ignored");

  // sticky status bits
  a_abort_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE11
    tgt_abort_q && !(cfg_wr_i && cfg_addr_i == `PBC_OFS_CMD_STAT && cfg_be_i[3] && cfg_wdata_i[`PBC_BIT_TGT_ABORT])
    |=> tgt_abort_q)
    else $error("abort status lost without clear");
  a_serr_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // see RULE13
    serr_sig_q && !(cfg_wr_i && cfg_addr_i == `PBC_OFS_CMD_STAT && cfg_be_i[3] && cfg_wdata_i[`PBC_BIT_SERR_SIG])
    |=> serr_sig_q)
    else $error("system error status lost without clear");

  // main scenarios
  c_claim: cover property (@(posedge mclk_i) disable iff (reset_i) mem_claim_o);
  c_abort: cover property (@(posedge mclk_i) disable iff (reset_i) target_abort_o);
  c_serr: cover property (@(posedge mclk_i) disable iff (reset_i) !serr_n_o);
  c_clear: cover property (@(posedge mclk_i) disable iff (reset_i) par_det_q ##1 !par_det_q);
  c_read_done: cover property (@(posedge mclk_i) disable iff (reset_i) cfg_q == PBC_READ_DONE);

endmodule

/* File: sim/pbc_host_model.sv */
// host side model that issues configuration cycles to the bridge function
`timescale 1ns/1ps
`include "pbc_defines.svh"
module pbc_host_model #(
  parameter bit SLAVE_MODE = 1'b0
) (
  input wire logic mclk_i,
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i,
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [11:0] cfg_addr_o,
  output logic [31:0] cfg_wdata_o,
  output logic [3:0] cfg_be_o
);
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 12'h000;
    cfg_wdata_o = 32'h0000_0000;
    cfg_be_o = 4'h0;
  end
  // one access: a single request pulse, then a bounded wait for the answer
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q, output logic ok);
    logic [31:0] dd;
    dd = d;
    ok = 1'b0;
    q = 32'h0000_0000;
    if (SLAVE_MODE && a == `PBC_OFS_CMD_STAT) dd[`PBC_BIT_MEM_EN] = 1'b0;
    @(posedge mclk_i);
    cfg_rd_o <= !wr;
    cfg_wr_o <= wr;
    cfg_addr_o <= a;
    cfg_wdata_o <= dd;
    cfg_be_o <= be;
    @(posedge mclk_i);
    cfg_rd_o <= 1'b0;
    cfg_wr_o <= 1'b0;
    // address, data and lanes stand until the answer is sampled
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge mclk_i);
      if (cfg_ack_i === 1'b1) begin
        ok = 1'b1;
        q = cfg_rdata_i;
      end
    end
    cfg_wdata_o <= ~dd; // released data no longer shows the old value
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the bridge function configuration header
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import pbc_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b1, cfg_rd, cfg_wr, cfg_ack, mem_req = 1'b0, mem_claim;
  logic par_err = 1'b0, abort_req = 1'b0, arb_mode = 1'b0, bus_held = 1'b0;
  logic serr_n, tabort, mem_en, connected;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr = 32'h0000_0000;
  logic [3:0] cfg_be;
  logic [7:0] int_line;
  int n_mismatch = 0, n_checks = 0;
  always #50 mclk_i = ~mclk_i;
  pbc_config_space #(.REVISION_ID(8'h5a)) pbc_config_space_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_be_i(cfg_be),
    .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .mem_claim_o(mem_claim), .par_err_i(par_err), .abort_req_i(abort_req), .arb_mode_i(arb_mode),
    .bus_held_i(bus_held), .serr_n_o(serr_n), .target_abort_o(tabort), .mem_enable_o(mem_en),
    .bus_connected_o(connected), .int_line_o(int_line));
  pbc_host_model pbc_host_model_i (.mclk_i(mclk_i), .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata),
    .cfg_rd_o(cfg_rd), .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_be_o(cfg_be));
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // register access helpers; a missing answer ends the run
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                     input logic [31:0] e, input string nm);
    logic [31:0] q;
    logic ok;
    pbc_host_model_i.xfer(w, a, d, be, q, ok);
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, 1'b1, ok);
      results();
    end else if (!w) `CHK(nm, e, q)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    acc(1'b1, a, d, be, 32'h0, "write");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    acc(1'b0, a, 32'h0, 4'hf, e, nm);
  endtask
  // one event pulse, then error and abort outputs one cycle later
  task automatic ev(input logic p, input logic b, input logic es, input logic et);
    par_err <= p;
    abort_req <= b;
    @(posedge mclk_i);
    par_err <= 1'b0;
    abort_req <= 1'b0;
    #1;
    `CHK("serr_n", es, serr_n)
    `CHK("tabort", et, tabort)
    @(posedge mclk_i);
  endtask
  task automatic claim(input logic [31:0] a, input logic e);
    @(posedge mclk_i);
    mem_req <= 1'b1;
    mem_addr <= a;
    @(posedge mclk_i);
    mem_req <= 1'b0;
    #1;
    `CHK("claim", e, mem_claim)
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    // constants and reset values
    rd(12'h104, 32'h0280_0000, "cmd_rst");
    rd(12'h108, 32'h0680_005a, "class");
    rd(12'h10c, 32'h0080_0000, "lat_hdr");
    rd(12'h110, 32'h0000_0000, "base_rst");
    rd(12'h13c, 32'h0000_0100, "int_rst");
    rd(12'h200, 32'h0000_0000, "unmapped");
    `CHK("conn_rst", 1'b0, connected)
    $display("test constants done");
    // command word: only three bits stick
    wr(12'h104, 32'hffff_ffff, 4'hf);
    rd(12'h104, 32'h0280_0142, "cmd_all");
    `CHK("conn", 1'b1, connected)
    `CHK("mem_en", 1'b1, mem_en)
    wr(12'h104, 32'h0000_0000, 4'hf);
    `CHK("conn_off", 1'b0, connected)
    $display("test command done");
    // parity and system error
    ev(1'b1, 1'b0, 1'b1, 1'b0);
    rd(12'h104, 32'h8280_0000, "par_ign");
    wr(12'h104, 32'h0000_0040, 4'hf);
    ev(1'b1, 1'b0, 1'b1, 1'b0);
    rd(12'h104, 32'hc280_0040, "serr_dis");
    wr(12'h104, 32'h4000_0000, 4'h8);
    rd(12'h104, 32'h8280_0040, "clr30");
    wr(12'h104, 32'h8000_0140, 4'hf);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(12'h104, 32'hc280_0140, "serr_on");
    wr(12'h104, 32'hc000_0000, 4'hf);
    rd(12'h104, 32'h0280_0000, "clr_all");
    $display("test errors done");
    // target abort gating
    ev(1'b0, 1'b1, 1'b1, 1'b0);
    arb_mode <= 1'b1;
    bus_held <= 1'b1;
    ev(1'b0, 1'b1, 1'b1, 1'b0);
    bus_held <= 1'b0;
    ev(1'b0, 1'b1, 1'b1, 1'b1);
    rd(12'h104, 32'h0a80_0000, "abort");
    wr(12'h104, 32'h0800_0000, 4'h8);
    rd(12'h104, 32'h0280_0000, "abort_clr");
    $display("test abort done");
    // window base and decode
    wr(12'h110, 32'hffff_ffff, 4'hf);
    rd(12'h110, 32'hfff0_0000, "base_ones");
    wr(12'h110, 32'habc0_0000, 4'hf);
    wr(12'h104, 32'h0000_0002, 4'hf);
    claim(32'habc1_2345, 1'b1);
    claim(32'habd0_0000, 1'b0);
    wr(12'h104, 32'h0000_0000, 4'hf);
    claim(32'habc1_2345, 1'b0);
    $display("test window done");
    // interrupt routing byte
    wr(12'h13c, 32'hffff_ffa5, 4'hf);
    rd(12'h13c, 32'h0000_01a5, "int");
    `CHK("int_line", 8'ha5, int_line)
    $display("test interrupt done");
    // reset in mid-run returns the stored fields to zero
    wr(12'h104, 32'h0000_0142, 4'hf);
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    `CHK("mem_en_rst", 1'b0, mem_en)
    `CHK("int_line_rst", 8'h00, int_line)
    rd(12'h104, 32'h0280_0000, "cmd_rst2");
    rd(12'h110, 32'h0000_0000, "base_rst2");
    $display("test reset done");
    results();
  end
endmodule
